// ### hdl/pmp_port.v
/*
 MAC-facing data port of a gigabit PHY: GMII, MII and RGMII receive and
 transmit signalling, receive and MII transmit clock generation.
 Assumes the PHY core on core_clk supplies receive bytes and line state and
 takes transmit bytes; MAC pins arrive asynchronously and are synchronised.
*/
// What this block does
// - MII transmit clock idle in GMII mode.
// - COL shows collision, half duplex only.
// - CRS shows carrier, half duplex only.
// - Bytes on RXD; MII uses low nibble.
// - MII mode holds RXD bits 7-4 low.
// - RX_DV exactly while frame data present.
// - RX_ER flags errored frame during transfer.
// - RX_ER with RXD signals partner LPI.
// - TX_CTL carries enable and error; decoded.
// - RXC at 100, 25, 2.5 MHz.
// - RX_CTL carries valid and error.
// - Idle RGMII RXD shows speed, duplex, link.
`timescale 1ns/1ps
`default_nettype none
`include "pmp_defs.vh"

module pmp_port (
    input wire core_clk,
    input wire rst_n,
    input wire if_sel,
    input wire [1:0] speed,
    input wire full_duplex,
    input wire link_up,
    input wire carrier,
    input wire collision,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire rx_error,
    input wire rx_lpi,
    output wire rx_take,
    output reg [7:0] tx_byte,
    output reg tx_strobe,
    output reg tx_error,
    output reg tx_lpi,
    output reg [7:0] rxd,
    output reg rx_dv,
    output reg rx_er,
    output wire rx_clk,
    output wire tx_clk,
    output wire col,
    output wire crs,
    output reg [3:0] rgmii_rxd,
    output reg rx_ctl,
    output wire rxc,
    input wire [7:0] txd,
    input wire tx_en,
    input wire tx_er,
    input wire gtx_clk,
    input wire [3:0] rgmii_txd,
    input wire tx_ctl,
    input wire txc
);
    localparam integer HALF_10_I = `PMP_HALF(`PMP_T10_PS);
    localparam integer HALF_100_I = `PMP_HALF(`PMP_T100_PS);
    localparam integer HALF_1000_I = `PMP_HALF(`PMP_T1000_PS);
    localparam [`PMP_CNT_W-1:0] HALF_10 = HALF_10_I[`PMP_CNT_W-1:0];
    localparam [`PMP_CNT_W-1:0] HALF_100 = HALF_100_I[`PMP_CNT_W-1:0];
    localparam [`PMP_CNT_W-1:0] HALF_1000 = HALF_1000_I[`PMP_CNT_W-1:0];

    wire rgmii = (if_sel == `PMP_IF_RGMII);
    wire gig = (speed == `PMP_SPD_1000);
    wire byte_mode = gig;
    reg [`PMP_CNT_W-1:0] half;
    reg [`PMP_CNT_W-1:0] cnt;
    reg lclk;

    always @* begin
        case (speed)
            `PMP_SPD_10: half = HALF_10;
            `PMP_SPD_100: half = HALF_100;
            default: half = HALF_1000;
        endcase
    end

    // Gigabit from a 200 MHz core rounds down to 100 MHz; real parts use a PLL.
    wire flip = (cnt >= half - 1'b1);
    wire rise = flip && !lclk;
    wire fall = flip && lclk;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= {`PMP_CNT_W{1'b0}};
            lclk <= 1'b0;
        end else if (flip) begin
            cnt <= {`PMP_CNT_W{1'b0}};
            lclk <= ~lclk;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign rxc = rgmii ? lclk : 1'b0;
    assign rx_clk = rgmii ? 1'b0 : lclk;
    assign tx_clk = (!rgmii && !gig) ? lclk : 1'b0;
    assign col = collision && !full_duplex;
    assign crs = carrier && !full_duplex;

    reg nib_hi;
    reg s_dv;
    reg s_er;
    reg s_lpi;
    reg s_car;
    reg [7:0] s_data;
    wire fetch = fall && (byte_mode || !nib_hi);
    assign rx_take = fetch;
    wire v_dv = fetch ? rx_valid : s_dv;
    wire v_er = fetch ? (rx_valid ? rx_error : rx_lpi) : s_er;
    wire v_lpi = fetch ? (!rx_valid && rx_lpi) : s_lpi;
    wire v_car = fetch ? carrier : s_car;
    wire [7:0] v_data = fetch ? rx_byte : s_data;
    wire [3:0] v_nib = (!byte_mode && nib_hi) ? v_data[7:4] : v_data[3:0];
    wire [3:0] status;
    assign status[`PMP_ST_LINK] = link_up;
    assign status[`PMP_ST_SPD_LO] = speed[0];
    assign status[`PMP_ST_SPD_HI] = speed[1];
    assign status[`PMP_ST_DUP] = full_duplex;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nib_hi <= 1'b0;
            s_dv <= 1'b0;
            s_er <= 1'b0;
            s_lpi <= 1'b0;
            s_car <= 1'b0;
            s_data <= `PMP_BYTE_ZERO;
            rxd <= `PMP_BYTE_ZERO;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rgmii_rxd <= `PMP_NIB_ZERO;
            rx_ctl <= 1'b0;
        end else if (fall) begin
            nib_hi <= byte_mode ? 1'b0 : ~nib_hi;
            s_dv <= v_dv;
            s_er <= v_er;
            s_lpi <= v_lpi;
            s_car <= v_car;
            s_data <= v_data;
            if (rgmii) begin
                rxd <= `PMP_BYTE_ZERO;
                rx_dv <= 1'b0;
                rx_er <= 1'b0;
                rx_ctl <= v_dv;
                if (v_dv)
                    rgmii_rxd <= v_nib;
                else if (v_lpi)
                    rgmii_rxd <= `PMP_LPI_NIB;
                else if (v_er || v_car)
                    rgmii_rxd <= `PMP_NIB_ZERO;
                else
                    rgmii_rxd <= status;
            end else begin
                rgmii_rxd <= `PMP_NIB_ZERO;
                rx_ctl <= 1'b0;
                rx_dv <= v_dv;
                rx_er <= v_er;
                if (v_dv)
                    rxd <= byte_mode ? v_data : {`PMP_NIB_ZERO, v_nib};
                else if (v_lpi)
                    rxd <= `PMP_LPI_BYTE;
                else
                    rxd <= `PMP_BYTE_ZERO;
            end
        end else if (rise && rgmii) begin
            rx_ctl <= s_dv ^ s_er;
            if (byte_mode && s_dv)
                rgmii_rxd <= s_data[7:4];
        end
    end

    // Pins from the MAC cross in on two flip-flops before any use.
    // RGMII data rides the same two flip-flops as its clock, so each nibble is seen with its edge.
    reg [16:0] sy1;
    reg [16:0] sy2;
    reg gclk_d;
    reg tclk_d;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= 17'h00000;
            sy2 <= 17'h00000;
            gclk_d <= 1'b0;
            tclk_d <= 1'b0;
        end else begin
            sy1 <= {rgmii_txd, gtx_clk, txc, tx_en, tx_er, tx_ctl, txd};
            sy2 <= sy1;
            gclk_d <= sy2[12];
            tclk_d <= sy2[11];
        end
    end
    wire [3:0] p_rtxd = sy2[16:13];
    wire [7:0] p_txd = sy2[7:0];
    wire p_en = sy2[10];
    wire p_er = sy2[9];
    wire p_ctl = sy2[8];
    wire g_rise = sy2[12] && !gclk_d;
    wire t_rise = sy2[11] && !tclk_d;
    wire t_fall = !sy2[11] && tclk_d;

    reg t_hi;
    reg [3:0] t_low;
    reg t_acc_er;
    reg r_en;
    reg [3:0] r_nib;
    // One nibble or byte event per clock of the MII or RGMII transmit path.
    wire n_ev = rgmii ? t_fall : (!gig && rise);
    wire [3:0] n_nib = rgmii ? r_nib : p_txd[3:0];
    wire n_en = rgmii ? r_en : p_en;
    wire n_er = rgmii ? (p_ctl ^ r_en) : p_er;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            t_hi <= 1'b0;
            t_low <= `PMP_NIB_ZERO;
            t_acc_er <= 1'b0;
            r_en <= 1'b0;
            r_nib <= `PMP_NIB_ZERO;
            tx_byte <= `PMP_BYTE_ZERO;
            tx_strobe <= 1'b0;
            tx_error <= 1'b0;
            tx_lpi <= 1'b0;
        end else begin
            tx_strobe <= 1'b0;
            if (rgmii && t_rise) begin
                r_en <= p_ctl;
                r_nib <= p_rtxd;
            end
            if (!rgmii && gig && g_rise) begin
                tx_lpi <= !p_en && p_er;
                if (p_en) begin
                    tx_byte <= p_txd;
                    tx_error <= p_er;
                    tx_strobe <= 1'b1;
                end
            end else if (n_ev) begin
                tx_lpi <= !n_en && n_er;
                if (!n_en) begin
                    t_hi <= 1'b0;
                    t_acc_er <= 1'b0;
                end else if (rgmii && gig) begin
                    tx_byte <= {p_rtxd, n_nib};
                    tx_error <= n_er;
                    tx_strobe <= 1'b1;
                end else if (!t_hi) begin
                    t_low <= n_nib;
                    t_acc_er <= n_er;
                    t_hi <= 1'b1;
                end else begin
                    tx_byte <= {n_nib, t_low};
                    tx_error <= t_acc_er || n_er;
                    tx_strobe <= 1'b1;
                    t_hi <= 1'b0;
                end
            end
        end
    end
endmodule // pmp_port
`default_nettype wire

// ### hdl/pmp_defs.vh
/*
 Constants shared by the MAC-side data port of the gigabit PHY: clock timing,
 speed codes, interface select and fixed receive codes.
 Assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef PMP_DEFS_VH
`define PMP_DEFS_VH

// Core clock period and link clock periods, in picoseconds.
`define PMP_CORE_PS 5000
`define PMP_T10_PS 400000
`define PMP_T100_PS 40000
`define PMP_T1000_PS 8000
// Half period in core cycles, never below one cycle.
`define PMP_HALF(p) ((((p) / 2) / `PMP_CORE_PS) < 1 ? 1 : (((p) / 2) / `PMP_CORE_PS))

// Link speed codes, as carried in the in-band status.
`define PMP_SPD_10 2'h0
`define PMP_SPD_100 2'h1
`define PMP_SPD_1000 2'h2

// Interface select.
`define PMP_IF_GMII 1'h0
`define PMP_IF_RGMII 1'h1

// Receive data pattern that marks Low Power Idle.
`define PMP_LPI_BYTE 8'h01
`define PMP_LPI_NIB 4'h1
`define PMP_NIB_ZERO 4'h0
`define PMP_BYTE_ZERO 8'h00

// In-band status nibble fields.
`define PMP_ST_LINK 0
`define PMP_ST_SPD_LO 1
`define PMP_ST_SPD_HI 2
`define PMP_ST_DUP 3

// Width of the link clock half-period counter.
`define PMP_CNT_W 7

`endif

// ### verification/pmp_port_checker.sv
/*
 Port checker for pmp_port.
 Assumes a bind into pmp_port; it sees only the top ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmp_port_checker (
    input wire core_clk,
    input wire rst_n,
    input wire if_sel,
    input wire [1:0] speed,
    input wire full_duplex,
    input wire link_up,
    input wire carrier,
    input wire collision,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire rx_error,
    input wire rx_lpi,
    input wire rx_take,
    input wire [7:0] rxd,
    input wire rx_dv,
    input wire rx_er,
    input wire rx_clk,
    input wire tx_clk,
    input wire col,
    input wire crs,
    input wire [3:0] rgmii_rxd,
    input wire rx_ctl,
    input wire rxc
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire gm = !if_sel && speed == 2'h2;
    wire mi = !if_sel && speed != 2'h2;
    wire idle = !rx_valid && !rx_lpi && !rx_error && !carrier;
    a_col_half: assert property (col == (collision && !full_duplex)) else $error("col");
    a_crs_half: assert property (crs == (carrier && !full_duplex)) else $error("crs");
    a_gmii_txclk: assert property (gm |-> !tx_clk) else $error("tx_clk");
    a_mii_upper: assert property (rx_take && mi |=> rxd[7:4] == 4'h0) else $error("upper");
    a_gmii_data: assert property (rx_take && gm && rx_valid |=> rxd == $past(rx_byte))
        else $error("rxd");
    a_dv_valid: assert property (rx_take && !if_sel |=> rx_dv == $past(rx_valid))
        else $error("rx_dv");
    a_er_frame: assert property (rx_take && !if_sel && rx_valid |=> rx_er == $past(rx_error))
        else $error("rx_er");
    a_er_lpi: assert property (rx_take && !if_sel && !rx_valid && rx_lpi |=> rx_er && rxd == 8'h01)
        else $error("lpi");
    a_ctl_valid: assert property (rx_take && if_sel |=> rx_ctl == $past(rx_valid))
        else $error("rx_ctl");
    a_idle_status: assert property (rx_take && if_sel && idle |=>
        rgmii_rxd == {$past(full_duplex), $past(speed), $past(link_up)}) else $error("status");
    a_rxc_quiet: assert property (!if_sel |-> !rxc) else $error("rxc");
    a_rxclk_quiet: assert property (if_sel |-> !rx_clk) else $error("rx_clk");
    c_gmii: cover property (rx_take && gm && rx_valid);
    c_lpi: cover property (rx_take && !if_sel && rx_lpi);
    c_rgmii: cover property (rx_take && if_sel);
    c_mii: cover property (rx_take && mi && rx_valid);
endmodule // pmp_port_checker
bind pmp_port pmp_port_checker u_chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .if_sel(if_sel),
    .speed(speed),
    .full_duplex(full_duplex),
    .link_up(link_up),
    .carrier(carrier),
    .collision(collision),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_error(rx_error),
    .rx_lpi(rx_lpi),
    .rx_take(rx_take),
    .rxd(rxd),
    .rx_dv(rx_dv),
    .rx_er(rx_er),
    .rx_clk(rx_clk),
    .tx_clk(tx_clk),
    .col(col),
    .crs(crs),
    .rgmii_rxd(rgmii_rxd),
    .rx_ctl(rx_ctl),
    .rxc(rxc)
);
`default_nettype wire

// ### verification/pmp_mac_model.sv
/*
 MAC model driving the RGMII transmit pins.
 Assumes the bench calls send in RGMII gigabit mode and send_gmii in GMII gigabit mode.
*/
`timescale 1ns/1ps
`default_nettype none
module pmp_mac_model (
    output logic txc,
    output logic [3:0] rgmii_txd,
    output logic tx_ctl,
    output logic [7:0] txd,
    output logic tx_en,
    output logic tx_er,
    output logic gtx_clk
);
    initial begin
        txc = 1'b0;
        rgmii_txd = 4'h5;
        tx_ctl = 1'b0;
        txd = 8'h00;
        tx_en = 1'b0;
        tx_er = 1'b0;
        gtx_clk = 1'b0;
    end
    // The clock runs only within frames; idle leaves data at the inverse of its last value.
    task automatic send(input logic [7:0] b, input logic e);
        rgmii_txd = b[3:0];
        tx_ctl = 1'b1;
        #12 txc = 1'b1;
        #12 rgmii_txd = b[7:4];
        tx_ctl = 1'b1 ^ e;
        #12 txc = 1'b0;
        #12;
    endtask
    task automatic idle;
        rgmii_txd = ~rgmii_txd;
        tx_ctl = 1'b0;
    endtask
    task automatic send_gmii(input logic [7:0] b, input logic en, input logic er);
        txd = b;
        tx_en = en;
        tx_er = er;
        #12 gtx_clk = 1'b1;
        #24 gtx_clk = 1'b0;
        #12;
    endtask
endmodule // pmp_mac_model
`default_nettype wire

// ### verification/pmp_port_tb.sv
/*
 Self-checking bench for pmp_port with a MAC model on the transmit pins.
 Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module pmp_port_tb;
    logic core_clk, rst_n, if_sel, full_duplex, link_up, carrier, collision;
    logic rx_valid, rx_error, rx_lpi;
    logic [1:0] speed;
    logic [7:0] rx_byte;
    wire rx_take, tx_strobe, tx_error, tx_lpi, rx_dv, rx_er, rx_clk, tx_clk, col, crs;
    wire rx_ctl, rxc, tx_en, tx_er, gtx_clk, tx_ctl, txc;
    wire [7:0] tx_byte, rxd, txd;
    wire [3:0] rgmii_rxd, rgmii_txd;
    int n_mismatch = 0;
    int cmp_count = 0;
    pmp_port dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .if_sel(if_sel),
        .speed(speed),
        .full_duplex(full_duplex),
        .link_up(link_up),
        .carrier(carrier),
        .collision(collision),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_error(rx_error),
        .rx_lpi(rx_lpi),
        .rx_take(rx_take),
        .tx_byte(tx_byte),
        .tx_strobe(tx_strobe),
        .tx_error(tx_error),
        .tx_lpi(tx_lpi),
        .rxd(rxd),
        .rx_dv(rx_dv),
        .rx_er(rx_er),
        .rx_clk(rx_clk),
        .tx_clk(tx_clk),
        .col(col),
        .crs(crs),
        .rgmii_rxd(rgmii_rxd),
        .rx_ctl(rx_ctl),
        .rxc(rxc),
        .txd(txd),
        .tx_en(tx_en),
        .tx_er(tx_er),
        .gtx_clk(gtx_clk),
        .rgmii_txd(rgmii_txd),
        .tx_ctl(tx_ctl),
        .txc(txc)
    );
    pmp_mac_model mac (
        .txc(txc),
        .rgmii_txd(rgmii_txd),
        .tx_ctl(tx_ctl),
        .txd(txd),
        .tx_en(tx_en),
        .tx_er(tx_er),
        .gtx_clk(gtx_clk)
    );
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for rx_take (s=0) or tx_strobe (s=1), then lets one more edge land.
    task wait_on(input int s);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((s ? tx_strobe : rx_take) !== 1'b1 && n < 400);
        if (n >= 400) n_mismatch++;
        @(negedge core_clk);
    endtask
    task t_gmii_rx;
        {if_sel, speed, rx_valid, rx_byte, rx_error, rx_lpi} = {3'h2, 1'h1, 8'hA5, 2'h0};
        wait_on(0);
        chk(rxd, 8'hA5);
        chk({7'h0, rx_dv}, 8'h01);
        chk({7'h0, tx_clk}, 8'h00);
        rx_error = 1'b1;
        wait_on(0);
        chk({7'h0, rx_er}, 8'h01);
        {rx_valid, rx_error, rx_lpi} = 3'h1;
        wait_on(0);
        chk({rx_dv, rx_er, rxd[5:0]}, 8'h41);
    endtask
    task t_gmii_tx;
        mac.send_gmii(8'h3E, 1'b1, 1'b0);
        @(negedge core_clk);
        chk(tx_byte, 8'h3E);
        chk({6'h0, tx_error, tx_lpi}, 8'h00);
        mac.send_gmii(8'h00, 1'b0, 1'b1);
        @(negedge core_clk);
        chk({6'h0, tx_error, tx_lpi}, 8'h01);
        mac.send_gmii(8'h00, 1'b0, 1'b0);
        @(negedge core_clk);
        chk({7'h0, tx_lpi}, 8'h00);
    endtask
    task t_mii_rx;
        {speed, rx_valid, rx_byte, rx_lpi} = {2'h1, 1'h1, 8'h3C, 1'h0};
        wait_on(0);
        chk(rxd, 8'h0C);
        {speed, rx_byte} = {2'h0, 8'hD2};
        wait_on(0);
        chk(rxd, 8'h02);
    endtask
    task t_col_crs;
        for (int fd = 0; fd < 2; fd++) begin
            {collision, carrier, full_duplex} = {2'h3, fd[0]};
            @(negedge core_clk);
            chk({6'h0, col, crs}, fd ? 8'h00 : 8'h03);
        end
        {collision, carrier} = 2'h0;
    endtask
    task t_rgmii;
        {if_sel, speed, link_up, rx_valid} = 5'h16;
        wait_on(0);
        chk({3'h0, rx_ctl, rgmii_rxd}, 8'h0B);
        {rx_valid, rx_byte} = 9'h196;
        wait_on(0);
        chk({3'h0, rx_ctl, rgmii_rxd}, 8'h16);
        speed = 2'h2;
        fork
            begin
                mac.send(8'h5A, 1'b0);
                mac.send(8'hC3, 1'b1);
                mac.idle;
            end
        join_none
        wait_on(1);
        chk({tx_byte[6:0], tx_error}, 8'hB4);
        wait_on(1);
        chk({tx_byte[6:0], tx_error}, 8'h87);
    endtask
    task test_done;
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        {rst_n, if_sel, full_duplex, link_up, carrier, collision, rx_valid, rx_error, rx_lpi} = 9'h0;
        speed = 2'h2;
        rx_byte = 8'h00;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_gmii_rx;
        t_gmii_tx;
        t_mii_rx;
        t_col_crs;
        t_rgmii;
        test_done;
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule // pmp_port_tb
`default_nettype wire
